// ---- logic/npos_host.sv ----
// Host controller that drives a NAND flash through its pins, ordered over AXI4-Lite
`timescale 1ns/1ps
// Overview of operation
// RQ1: Device powers up in read mode
// RQ2: Repeat reads send only confirm code
// RQ3: Wait ready after read confirm, then stream
// RQ4: Random data output redirects output column
// RQ5: No random output during cache read
// RQ6: Cache read: setup, address, cache confirm
// RQ7: Cache read start column forced zero
// RQ8: Ready returns after cache read latency
// RQ9: Device status bits report cache progress
// RQ10: Exit cache read drops prefetched page
// RQ11: Partial program of any length accepted
// RQ12: At most eight partial programs per page
// RQ13: Program data addresses sequential, one block
// RQ14: Program confirm only after data loaded
// RQ15: Random data input: code, two columns
// RQ16: Program error only for failed zeros
// RQ17: Only status or reset while programming
// RQ18: Ready high when programming completes
// RQ19: Device stays in status mode afterwards
// RQ20: Copy-back: source read, then target program
// RQ21: Copy-back failure flagged in status
// RQ22: Copy-back pages share parity and plane
// RQ23: Fixed command codes per operation
// RQ24: Commands latched on write-enable with latch
// RQ25: Extra address cycles ignored by device
// RQ26: Copy-back buffer patchable by data input
// RQ27: Ready low during copy-back transfers
module npos_host
   import npos_pkg::*;
#(
   parameter int NUM_ADDR    = 5,
   parameter int PLANE_BIT   = 16,
   parameter bit CHECK_PLANE = 1'b0
)
(
   // Clock and reset
   input  wire logic        clock,
   input  wire logic        rst_b,
   // AXI4-Lite slave
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // NAND pins
   output npos_pins_s       nand_pins,
   input  wire logic [7:0]  nand_io_in,
   input  wire logic        nand_rb
);
   import npos_pkg::*;

   typedef enum logic [1:0] {S_IDLE = 2'b00, S_LOW = 2'b01, S_HIGH = 2'b11, S_WAIT = 2'b10}
      npos_state_e;

   npos_state_e             state_ff;
   npos_pins_s              pins_ff;
   npos_step_s              seq_ff [SEQ_DEPTH];
   npos_step_s              seq    [SEQ_DEPTH];
   logic [3:0]              seq_n;
   logic [3:0]              len_ff;
   logic [2:0]              idx_ff;
   logic [7:0]              cnt_ff;
   logic                    run_ff;
   logic [11:0]             col_ff;
   logic [23:0]             row_ff;
   logic [7:0]              wdata_ff;
   logic [7:0]              rdata_ff;
   logic [2:0]              rb_sync_ff;
   logic                    rb_ff;
   logic [7:0]              io_s1_ff;
   logic [7:0]              io_s2_ff;
   logic [7:0]              io_s3_ff;
   logic                    primed_ff;
   logic                    cache_ff;
   logic                    pgm_open_ff;
   logic                    loaded_ff;
   logic                    copy_src_ff;
   logic [23:0]             src_row_ff;
   logic [23:0]             part_row_ff;
   logic [3:0]              part_cnt_ff;
   logic                    refused_ff;
   logic                    parity_ff;
   logic                    aw_hold_ff;
   logic                    w_hold_ff;
   logic [7:0]              aw_addr_ff;
   logic [31:0]             w_data_ff;
   logic [3:0]              w_strb_ff;
   logic                    wr_go;
   logic                    start;
   logic                    refuse;
   logic                    par_bad;
   logic                    part_full;
   npos_op_e                op;
   logic [7:0]              abyte  [5];

   // ---------------------------------------------------------------
   // AXI4-Lite write and read channels
   // ---------------------------------------------------------------
   assign wr_go = aw_hold_ff && w_hold_ff && !s_axi_bvalid;
   assign op    = npos_op_e'(w_data_ff[3:0]);
   assign start = wr_go && aw_addr_ff == REG_CMD && w_strb_ff[0];

   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         aw_hold_ff    <= 1'b0;
         w_hold_ff     <= 1'b0;
         aw_addr_ff    <= 8'h00;
         w_data_ff     <= 32'h0000_0000;
         w_strb_ff     <= 4'h0;
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_hold_ff    <= 1'b1;
            aw_addr_ff    <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_hold_ff    <= 1'b1;
            w_data_ff    <= s_axi_wdata;
            w_strb_ff    <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (wr_go)
         begin
            aw_hold_ff   <= 1'b0;
            w_hold_ff    <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (aw_addr_ff == REG_CMD || aw_addr_ff == REG_COL ||
                             aw_addr_ff == REG_ROW || aw_addr_ff == REG_WDATA ||
                             aw_addr_ff == REG_STATUS) ? RESP_OKAY : RESP_SLVERR;
         end
         if (s_axi_bvalid && s_axi_bready)
         begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rresp   <= RESP_OKAY;
         unique case (s_axi_araddr)
            REG_COL:    s_axi_rdata <= {20'h0_0000, col_ff};
            REG_ROW:    s_axi_rdata <= {8'h00, row_ff};
            REG_WDATA:  s_axi_rdata <= {24'h00_0000, wdata_ff};
            REG_STATUS: s_axi_rdata <= {8'h00, rdata_ff, 4'h0, part_cnt_ff, loaded_ff,
                                        pgm_open_ff, cache_ff, parity_ff, refused_ff,
                                        copy_src_ff, rb_ff, run_ff};
            REG_CMD:    s_axi_rdata <= 32'h0000_0000;
            default:
            begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= RESP_SLVERR;
            end
         endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // Address, column and data registers
   // ---------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         col_ff   <= 12'h000;
         row_ff   <= 24'h00_0000;
         wdata_ff <= 8'h00;
      end
      else if (wr_go)
      begin
         if (aw_addr_ff == REG_COL && w_strb_ff[0])
            col_ff[7:0] <= w_data_ff[7:0];
         if (aw_addr_ff == REG_COL && w_strb_ff[1])
            col_ff[11:8] <= w_data_ff[11:8];
         for (int b = 0; b < 3; b++)
            if (aw_addr_ff == REG_ROW && w_strb_ff[b])
               row_ff[b*8 +: 8] <= w_data_ff[b*8 +: 8];
         if (aw_addr_ff == REG_WDATA && w_strb_ff[0])
            wdata_ff <= w_data_ff[7:0];
      end
   end

   // ---------------------------------------------------------------
   // Operation check and step list
   // ---------------------------------------------------------------
   assign par_bad   = (row_ff[0] != src_row_ff[0]) ||
                      (CHECK_PLANE && row_ff[PLANE_BIT] != src_row_ff[PLANE_BIT]); // see RQ22
   assign part_full = (row_ff == part_row_ff) && (part_cnt_ff == MAX_PARTIAL);   // see RQ12

   always_comb
   begin
      refuse = run_ff;
      unique case (op)
         OP_RAND_OUT: refuse = run_ff || cache_ff;                          // see RQ5
         OP_RAND_IN:  refuse = run_ff || !pgm_open_ff;                      // see RQ15
         OP_DATA_WR:  refuse = run_ff || !pgm_open_ff;
         OP_CONFIRM:  refuse = run_ff || !loaded_ff || part_full;           // see RQ14
         OP_COPY_DST: refuse = run_ff || !copy_src_ff || par_bad;           // see RQ22
         default:     refuse = run_ff || op > OP_COPY_DST;
      endcase
   end

   always_comb
   begin
      abyte[0] = (op == OP_CACHE) ? 8'h00 : col_ff[7:0];                  // see RQ7
      abyte[1] = (op == OP_CACHE) ? 8'h00 : {4'h0, col_ff[11:8]};
      abyte[2] = row_ff[7:0];
      abyte[3] = row_ff[15:8];
      abyte[4] = row_ff[23:16];
      for (int i = 0; i < SEQ_DEPTH; i++)
         seq[i] = '{kind: K_WAIT, val: 8'h00};
      seq_n = 4'h0;
      unique case (op)
         OP_READ, OP_READ_NEXT, OP_CACHE, OP_COPY_SRC:
         begin
            if (op == OP_READ_NEXT && primed_ff)
            begin
               seq[0] = '{kind: K_CMD, val: CMD_READ_GO};                   // see RQ2
               seq_n  = 4'h2;
            end
            else
            begin
               seq[0] = '{kind: K_CMD, val: CMD_READ_SETUP};                // see RQ23
               seq_n  = 4'h1;
               for (int i = 0; i < 5; i++)                                  // see RQ25
                  if (i < ((op == OP_COPY_SRC) ? COPY_ADDR_CYC : NUM_ADDR))
                  begin
                     seq[seq_n[2:0]] = '{kind: K_ADDR, val: abyte[i]};
                     seq_n = seq_n + 4'h1;
                  end
               seq[seq_n[2:0]] = '{kind: K_CMD, val: (op == OP_CACHE) ? CMD_CACHE_GO :
                                   (op == OP_COPY_SRC) ? CMD_COPY_GO : CMD_READ_GO}; // see RQ6
               seq_n = seq_n + 4'h2;                                        // see RQ27
            end
         end
         OP_PROG, OP_COPY_DST:
         begin
            seq[0] = '{kind: K_CMD, val: (op == OP_PROG) ? CMD_PROG_SETUP : CMD_RAND_IN};
            seq_n  = 4'h1;
            for (int i = 0; i < 5; i++)                                     // see RQ20
               if (i < ((op == OP_COPY_DST) ? COPY_ADDR_CYC : NUM_ADDR))
               begin
                  seq[seq_n[2:0]] = '{kind: K_ADDR, val: abyte[i]};
                  seq_n = seq_n + 4'h1;
               end
         end
         OP_RAND_OUT:
         begin
            seq[0] = '{kind: K_CMD, val: CMD_ROUT_SETUP};                  // see RQ4
            seq[1] = '{kind: K_ADDR, val: abyte[0]};
            seq[2] = '{kind: K_ADDR, val: abyte[1]};
            seq[3] = '{kind: K_CMD, val: CMD_ROUT_GO};
            seq_n  = 4'h4;
         end
         OP_RAND_IN:
         begin
            seq[0] = '{kind: K_CMD, val: CMD_RAND_IN};                     // see RQ15
            seq[1] = '{kind: K_ADDR, val: abyte[0]};
            seq[2] = '{kind: K_ADDR, val: abyte[1]};
            seq_n  = 4'h3;
         end
         OP_CONFIRM, OP_CACHE_EXIT:
         begin
            seq[0] = '{kind: K_CMD, val: (op == OP_CONFIRM) ? CMD_PROG_GO : CMD_CACHE_EXIT};
            seq_n  = 4'h2;                                                  // see RQ17
         end
         OP_DATA_WR:
         begin
            seq[0] = '{kind: K_WR, val: wdata_ff};                          // see RQ13
            seq_n  = 4'h1;
         end
         OP_STATUS:
         begin
            seq[0] = '{kind: K_CMD, val: CMD_STATUS};
            seq[1] = '{kind: K_RD, val: 8'h00};
            seq_n  = 4'h2;
         end
         default:
         begin
            seq[0] = '{kind: K_RD, val: 8'h00};                             // see RQ3
            seq_n  = 4'h1;
         end
      endcase
   end

   // ---------------------------------------------------------------
   // Mode tracking and sticky errors
   // ---------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         primed_ff   <= 1'b0;
         cache_ff    <= 1'b0;
         pgm_open_ff <= 1'b0;
         loaded_ff   <= 1'b0;
         copy_src_ff <= 1'b0;
         src_row_ff  <= 24'h00_0000;
         part_row_ff <= 24'hFF_FFFF;
         part_cnt_ff <= 4'h0;
         refused_ff  <= 1'b0;
         parity_ff   <= 1'b0;
      end
      else
      begin
         if (wr_go && aw_addr_ff == REG_STATUS && w_strb_ff[0])
         begin
            refused_ff <= refused_ff && !w_data_ff[ST_REFUSED];
            parity_ff  <= parity_ff && !w_data_ff[ST_PARITY];
         end
         if (start && refuse)
         begin
            refused_ff <= 1'b1;
            if (op == OP_COPY_DST && copy_src_ff && par_bad)
               parity_ff <= 1'b1;
         end
         else if (start)
         begin
            primed_ff <= (op == OP_READ || op == OP_READ_NEXT || op == OP_DATA_RD ||
                          (op == OP_RAND_OUT && primed_ff));                 // see RQ19
            if (op == OP_CACHE)
               cache_ff <= 1'b1;
            else if (op == OP_CACHE_EXIT || op == OP_READ || op == OP_PROG)
               cache_ff <= 1'b0;                                            // see RQ10
            if (op == OP_PROG || op == OP_COPY_DST)
               pgm_open_ff <= 1'b1;
            else if (op != OP_DATA_WR && op != OP_RAND_IN && op != OP_STATUS)
               pgm_open_ff <= 1'b0;
            if (op == OP_PROG || op == OP_CONFIRM || op == OP_READ || op == OP_CACHE)
               loaded_ff <= 1'b0;
            else if (op == OP_DATA_WR || op == OP_COPY_DST)
               loaded_ff <= 1'b1;                                           // see RQ26
            if (op == OP_COPY_SRC)
            begin
               copy_src_ff <= 1'b1;
               src_row_ff  <= row_ff;
            end
            else if (op != OP_STATUS)
               copy_src_ff <= 1'b0;
            if (op == OP_CONFIRM)
            begin
               part_row_ff <= row_ff;
               part_cnt_ff <= (row_ff == part_row_ff) ? part_cnt_ff + 4'h1 : 4'h1; // see RQ12
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // Pin input synchronisers
   // ---------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rb_sync_ff <= 3'h0;
         rb_ff      <= 1'b0;
         io_s1_ff   <= 8'h00;
         io_s2_ff   <= 8'h00;
         io_s3_ff   <= 8'h00;
      end
      else
      begin
         rb_sync_ff <= {rb_sync_ff[1:0], nand_rb};
         if (rb_sync_ff[1] == rb_sync_ff[2])
            rb_ff <= rb_sync_ff[2];
         io_s1_ff <= nand_io_in;
         io_s2_ff <= io_s1_ff;
         io_s3_ff <= io_s2_ff;
      end
   end

   // ---------------------------------------------------------------
   // Pin sequencer
   // ---------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state_ff <= S_IDLE;
         pins_ff  <= PINS_IDLE;
         run_ff   <= 1'b0;
         idx_ff   <= 3'h0;
         len_ff   <= 4'h0;
         cnt_ff   <= 8'h00;
         rdata_ff <= 8'h00;
         for (int i = 0; i < SEQ_DEPTH; i++)
            seq_ff[i] <= '{kind: K_WAIT, val: 8'h00};
      end
      else
      begin
         unique case (state_ff)
            S_IDLE:
            begin
               if (start && !refuse)
               begin
                  seq_ff <= seq;
                  len_ff <= seq_n;
                  idx_ff <= 3'h0;
                  run_ff <= 1'b1;
               end
               else if (run_ff)
               begin
                  pins_ff.ce_b   <= 1'b0;
                  pins_ff.io_out <= seq_ff[idx_ff].val;
                  cnt_ff         <= (seq_ff[idx_ff].kind == K_WAIT) ? WB_CYC : LOW_CYC;
                  state_ff       <= (seq_ff[idx_ff].kind == K_WAIT) ? S_WAIT : S_LOW;
                  pins_ff.cle    <= seq_ff[idx_ff].kind == K_CMD;           // see RQ24
                  pins_ff.ale    <= seq_ff[idx_ff].kind == K_ADDR;
                  pins_ff.io_oe  <= seq_ff[idx_ff].kind inside {K_CMD, K_ADDR, K_WR};
                  pins_ff.we_b   <= !(seq_ff[idx_ff].kind inside {K_CMD, K_ADDR, K_WR});
                  pins_ff.re_b   <= seq_ff[idx_ff].kind != K_RD;
               end
               else
                  pins_ff <= PINS_IDLE;
            end
            S_LOW:
            begin
               cnt_ff <= cnt_ff - 8'h01;
               if (cnt_ff == 8'h01)
               begin
                  if (!pins_ff.re_b)
                     rdata_ff <= io_s3_ff;
                  pins_ff.we_b <= 1'b1;
                  pins_ff.re_b <= 1'b1;
                  cnt_ff       <= HIGH_CYC;
                  state_ff     <= S_HIGH;
               end
            end
            S_HIGH:
            begin
               cnt_ff <= cnt_ff - 8'h01;
               if (cnt_ff == 8'h01)
               begin
                  pins_ff.cle   <= 1'b0;
                  pins_ff.ale   <= 1'b0;
                  pins_ff.io_oe <= 1'b0;
                  idx_ff        <= idx_ff + 3'h1;
                  run_ff        <= {1'b0, idx_ff} + 4'h1 < len_ff;
                  state_ff      <= S_IDLE;
               end
            end
            S_WAIT:
            begin
               if (cnt_ff != 8'h00)
                  cnt_ff <= cnt_ff - 8'h01;
               else if (rb_ff)                                              // see RQ8
               begin
                  idx_ff   <= idx_ff + 3'h1;
                  run_ff   <= {1'b0, idx_ff} + 4'h1 < len_ff;
                  state_ff <= S_IDLE;
               end
            end
         endcase
      end
   end

   assign nand_pins = pins_ff;

endmodule

// ---- logic/npos_pkg.sv ----
// Shared constants, types and register map of the NAND page sequencer host
package npos_pkg;
   // ---------------------------------------------------------------
   // Command codes
   // ---------------------------------------------------------------
   localparam logic [7:0] CMD_READ_SETUP = 8'h00;
   localparam logic [7:0] CMD_READ_GO    = 8'h30;
   localparam logic [7:0] CMD_CACHE_GO   = 8'h31;
   localparam logic [7:0] CMD_CACHE_EXIT = 8'h34;
   localparam logic [7:0] CMD_COPY_GO    = 8'h35;
   localparam logic [7:0] CMD_PROG_SETUP = 8'h80;
   localparam logic [7:0] CMD_PROG_GO    = 8'h10;
   localparam logic [7:0] CMD_RAND_IN    = 8'h85;
   localparam logic [7:0] CMD_ROUT_SETUP = 8'h05;
   localparam logic [7:0] CMD_ROUT_GO    = 8'hE0;
   localparam logic [7:0] CMD_STATUS     = 8'h70;
   // ---------------------------------------------------------------
   // Register map and status fields
   // ---------------------------------------------------------------
   localparam logic [7:0] REG_CMD    = 8'h00;
   localparam logic [7:0] REG_COL    = 8'h04;
   localparam logic [7:0] REG_ROW    = 8'h08;
   localparam logic [7:0] REG_WDATA  = 8'h0C;
   localparam logic [7:0] REG_STATUS = 8'h10;
   localparam int         ST_REFUSED = 2;
   localparam int         ST_PARITY  = 3;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ---------------------------------------------------------------
   // Timing and counts
   // ---------------------------------------------------------------
   localparam int CLK_MHZ     = 200;
   localparam int WE_LOW_NS   = 25;
   localparam int WE_HIGH_NS  = 15;
   localparam int WB_NS       = 100;
   localparam int LOW_CYC_I   = (WE_LOW_NS * CLK_MHZ + 999) / 1000;
   localparam int HIGH_CYC_I  = (WE_HIGH_NS * CLK_MHZ + 999) / 1000;
   localparam int WB_CYC_I    = (WB_NS * CLK_MHZ + 999) / 1000;
   localparam logic [7:0] LOW_CYC  = 8'(LOW_CYC_I < 3 ? 3 : LOW_CYC_I);
   localparam logic [7:0] HIGH_CYC = 8'(HIGH_CYC_I < 1 ? 1 : HIGH_CYC_I);
   localparam logic [7:0] WB_CYC   = 8'(WB_CYC_I < 1 ? 1 : WB_CYC_I);
   localparam logic [3:0] MAX_PARTIAL   = 4'h8;
   localparam int         COPY_ADDR_CYC = 4;
   localparam int         SEQ_DEPTH     = 8;
   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [3:0] {
      OP_READ = 4'h0, OP_READ_NEXT = 4'h1, OP_CACHE = 4'h2, OP_CACHE_EXIT = 4'h3,
      OP_RAND_OUT = 4'h4, OP_PROG = 4'h5, OP_RAND_IN = 4'h6, OP_CONFIRM = 4'h7,
      OP_DATA_WR = 4'h8, OP_DATA_RD = 4'h9, OP_STATUS = 4'hA, OP_COPY_SRC = 4'hB,
      OP_COPY_DST = 4'hC
   } npos_op_e;
   typedef enum logic [2:0] {
      K_CMD = 3'h0, K_ADDR = 3'h1, K_WR = 3'h2, K_RD = 3'h3, K_WAIT = 3'h4
   } npos_kind_e;
   typedef struct packed {
      npos_kind_e kind;
      logic [7:0] val;
   } npos_step_s;
   typedef struct packed {
      logic       ce_b;
      logic       cle;
      logic       ale;
      logic       we_b;
      logic       re_b;
      logic       io_oe;
      logic [7:0] io_out;
   } npos_pins_s;
   localparam npos_pins_s PINS_IDLE = '{ce_b: 1'b1, cle: 1'b0, ale: 1'b0, we_b: 1'b1,
                                        re_b: 1'b1, io_oe: 1'b0, io_out: 8'h00};
endpackage

// ---- tb/npos_host_props.sv ----
// Pin protocol checker of the sequencer host
`timescale 1ns/1ps
module npos_host_props
   import npos_pkg::*;
(
   // Clock, reset, pins
   input wire logic clock,
   input wire logic rst_b,
   input npos_pins_s nand_pins
);
   npos_pins_s p;
   assign p = nand_pins;
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_b);
   sequence s_low; !p.we_b [*5] ##1 p.we_b; endsequence
   property p_low; $fell(p.we_b) |-> s_low; endproperty
   property p_excl; !(p.cle && p.ale); endproperty
   property p_oe; (p.cle || p.ale) && !p.we_b |-> p.io_oe; endproperty
   property p_hold; !p.we_b && !$fell(p.we_b) |-> $stable(p.io_out); endproperty
   property p_latch; $rose(p.we_b) && $past(p.cle) |-> p.cle && $stable(p.io_out); endproperty
   property p_read; !p.re_b |-> !p.io_oe && !p.ce_b && p.we_b; endproperty
   property p_ce; !p.we_b |-> !p.ce_b; endproperty
   property p_wait; $rose(p.we_b) && p.cle && p.io_out inside {8'h30, 8'h31, 8'h35}
      |-> p.re_b [*8]; endproperty
   a_low: assert property (p_low) else $error("width");
   a_excl: assert property (p_excl) else $error("latch clash");
   a_oe: assert property (p_oe) else $error("undriven");
   a_hold: assert property (p_hold) else $error("io moved");
   a_latch: assert property (p_latch) else $error("no hold");
   a_read: assert property (p_read) else $error("bus clash");
   a_ce: assert property (p_ce) else $error("unselected");
   a_wait: assert property (p_wait) else $error("early read");
endmodule
bind npos_host npos_host_props chk_u (.*);

// ---- tb/npos_flash_model.sv ----
// Behavioural flash device facing the sequencer host
`timescale 1ns/1ps
module npos_flash_model
   import npos_pkg::*;
(
   // Clock and pins
   input wire logic   clock,
   input npos_pins_s  nand_pins,
   output logic [7:0] nand_io_in,
   output logic       nand_rb
);
   npos_pins_s p, q = PINS_IDLE;
   logic [7:0] cmd = 8'h00, col = 8'h00, last = 8'h00;
   logic [2:0] n = 3'h0;
   int         busy = 0;
   wire        up = p.we_b && !q.we_b;
   assign p = nand_pins;
   assign nand_rb = busy == 0;
   // Released bus toggles so a stale byte never reads back
   assign nand_io_in = p.re_b | p.ce_b ? ~last : cmd == CMD_STATUS ?
      {1'b1, nand_rb, nand_rb, 5'h00} : col ^ 8'h5A;
   always @(posedge clock)
   begin
      q <= p;
      last <= nand_io_in;
      busy <= busy > 0 ? busy - 1 : 0;
      if (up && p.cle && (nand_rb || p.io_out == CMD_STATUS))
      begin
         cmd <= p.io_out;
         n <= 3'h0;
         if (p.io_out inside {CMD_READ_GO, CMD_CACHE_GO, CMD_COPY_GO, CMD_PROG_GO})
            busy <= 40;
      end
      if (up && p.ale && n == 3'h0) col <= p.io_out;
      if (up && p.ale) n <= n + 3'h1;
      if (p.re_b && !q.re_b && cmd != CMD_STATUS) col <= col + 8'h01;
   end
endmodule

// ---- tb/npos_host_tb.sv ----
// Self-checking bench of the sequencer host
`timescale 1ns/1ps
module npos_host_tb
   import npos_pkg::*;
;
   logic clock = 0, rst_b = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic s_axi_arready, s_axi_rvalid, nand_rb;
   logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, nand_io_in;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata, st;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
   logic [23:0] r;
   logic [11:0] c;
   npos_pins_s nand_pins;
   int fails = 0, cmp_count = 0, cyc = 0;
   npos_host dut_u (.*);
   npos_flash_model dev_u (.*);
   always #2.5 clock = ~clock;
   function automatic logic [7:0] pg(input logic [7:0] a);
      return a ^ 8'h5A;
   endfunction
   task automatic chk(input string nm, input logic [31:0] e, s);
      cmp_count++;
      if (e !== s) begin fails++; $display("BAD %s exp %h got %h", nm, e, s); end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1; s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      do begin @(posedge clock); if (s_axi_awready) s_axi_awvalid <= 0;
         if (s_axi_wready) s_axi_wvalid <= 0; end while (s_axi_bvalid !== 1'b1);
      rsp = s_axi_bresp; s_axi_bready <= 0; @(posedge clock);
   endtask
   task automatic rd(input logic [7:0] a);
      s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
      do begin @(posedge clock); if (s_axi_arready) s_axi_arvalid <= 0; end
      while (s_axi_rvalid !== 1'b1);
      st = s_axi_rdata; rsp = s_axi_rresp; s_axi_rready <= 0; @(posedge clock);
   endtask
   task automatic op(input npos_op_e o);
      wr(REG_CMD, 32'(o));
      do rd(REG_STATUS); while (st[0] !== 1'b0);
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   always @(posedge clock) if (++cyc == 40000) begin fails++; wrap_up(); end
   initial
   begin
      void'($urandom(20621));
      repeat (12) @(posedge clock);
      rst_b <= 1;
      repeat (6) @(posedge clock);
      rd(REG_STATUS); chk("ready", 2'h2, st[1:0]);
      wr(8'h40, 0); chk("bresp", RESP_SLVERR, rsp);
      rd(8'h44); chk("rresp", RESP_SLVERR, rsp);
      for (int k = 0; k < 3; k++)
      begin
         c = k == 0 ? 12'h0FF : 12'($urandom);
         wr(REG_COL, 32'(c)); wr(REG_ROW, $urandom); op(OP_READ);
         op(OP_DATA_RD); chk("rd0", pg(c[7:0]), st[23:16]);
         op(OP_DATA_RD); chk("rd1", pg(c[7:0] + 8'h01), st[23:16]);
         c = 12'($urandom); wr(REG_COL, 32'(c)); op(OP_RAND_OUT);
         op(OP_DATA_RD); chk("rout", pg(c[7:0]), st[23:16]);
         op(OP_READ_NEXT); chk("next", 1'b0, st[3]);
      end
      op(OP_CACHE); chk("cache", 1'b1, st[5]);
      op(OP_DATA_RD); chk("ccol", pg(8'h00), st[23:16]);
      op(OP_RAND_OUT); chk("crout", 1'b1, st[3]);
      op(OP_CACHE_EXIT); chk("exit", 1'b0, st[5]);
      r = 24'($urandom) & 24'hFFFFFE;
      for (int k = 0; k < 2; k++)
      begin
         wr(REG_STATUS, 32'hC); wr(REG_ROW, 32'(r)); op(OP_COPY_SRC);
         wr(REG_ROW, 32'(r) + 32'(k + 1)); op(OP_COPY_DST);
         chk("parity", k == 0, st[4]);
      end
      wr(REG_STATUS, 32'hC); wr(REG_ROW, 32'(r)); op(OP_PROG);
      op(OP_CONFIRM); chk("empty", 1'b1, st[3]);
      for (int i = 0; i < 9; i++)
      begin
         wr(REG_STATUS, 32'hC); op(OP_PROG); wr(REG_COL, $urandom); op(OP_RAND_IN);
         wr(REG_WDATA, $urandom); op(OP_DATA_WR);
         op(OP_CONFIRM); chk("partial", i == 8, st[3]);
      end
      op(OP_STATUS); chk("status", 8'hE0, st[23:16]);
      op(OP_DATA_RD); chk("stay", 8'hE0, st[23:16]);
      wrap_up();
   end
endmodule
